// >>> verilog/ccr_pkg.sv
// package with the register map, field layout and state type of the config slice
package ccr_pkg;

  // register offsets inside their pages
  localparam logic [11:0] CCR_OFS_LANE_AMPLITUDE_SELECT = 12'h03d;
  localparam logic [11:0] CCR_OFS_LOW_RATE_ENABLE_ONE = 12'h03f;
  localparam logic [11:0] CCR_OFS_LOW_RATE_ENABLE_TWO = 12'h042;
  localparam logic [11:0] CCR_OFS_TIMING_REFERENCE_CONTROL = 12'h057;
  localparam logic [11:0] CCR_OFS_SYNC_POLARITY_CONTROL = 12'h058;
  localparam logic [11:0] CCR_OFS_DIGITAL_GAIN_CONTROL = 12'h0a6;

  // page select registers, written with m = 0
  localparam logic [11:0] CCR_OFS_ANALOG_PAGE = 12'h011;
  localparam logic [11:0] CCR_OFS_DIG_PAGE_LO = 12'h012;
  localparam logic [11:0] CCR_OFS_DIG_PAGE_MID = 12'h013;
  localparam logic [11:0] CCR_OFS_DIG_PAGE_HI = 12'h014;

  // page values
  localparam logic [7:0] CCR_PAGE_MASTER = 8'h00;
  localparam logic [7:0] CCR_PAGE_CONVERTER = 8'hff;
  localparam logic [23:0] CCR_PAGE_DIG_CHAN_A = 24'h610000;
  localparam logic [23:0] CCR_PAGE_DIG_CHAN_B = 24'h610100;

  // field positions
  localparam int CCR_AMP_LSB = 0;
  localparam int CCR_REF_SRC_BIT = 3;
  localparam int CCR_REF_LVL_BIT = 4;
  localparam int CCR_SYNC_INV_BIT = 5;
  localparam int CCR_LOW_RATE_A_BIT = 2;
  localparam int CCR_LOW_RATE_B_BIT = 4;
  localparam int CCR_GAIN_LSB = 0;

  // reset values
  localparam logic [2:0] CCR_RST_AMP = 3'h0;
  localparam logic [3:0] CCR_RST_GAIN = 4'h0;
  localparam logic CCR_RST_BIT = 1'b0;
  localparam logic [7:0] CCR_RST_ANALOG_PAGE = 8'h00;
  localparam logic [23:0] CCR_RST_DIG_PAGE = 24'h000000;

  // serial frame: rw, m, two spare bits, 12 address bits, 8 data bits
  localparam logic [4:0] CCR_FRAME_BITS = 5'h18;
  localparam logic [4:0] CCR_HEADER_BITS = 5'h10;

  // lane amplitude in millivolts peak-to-peak per code
  localparam logic [9:0] CCR_VOD_MV_0 = 10'd860;
  localparam logic [9:0] CCR_VOD_MV_1 = 10'd810;
  localparam logic [9:0] CCR_VOD_MV_2 = 10'd770;
  localparam logic [9:0] CCR_VOD_MV_3 = 10'd745;
  localparam logic [9:0] CCR_VOD_MV_4 = 10'd960;
  localparam logic [9:0] CCR_VOD_MV_5 = 10'd930;
  localparam logic [9:0] CCR_VOD_MV_6 = 10'd905;
  localparam logic [9:0] CCR_VOD_MV_7 = 10'd880;

  // stored register fields
  typedef struct packed {
    logic [2:0] lane_amplitude_sel;
    logic timing_ref_source_sel;
    logic timing_ref_level_bit;
    logic sync_request_invert;
    logic low_rate_enable_a;
    logic low_rate_enable_b;
    logic [3:0] gain_a;
    logic [3:0] gain_b;
  } ccr_cfg_s;

  // whole module state
  typedef struct packed {
    ccr_cfg_s cfg;
    logic [7:0] analog_page;
    logic [23:0] dig_page;
    logic [22:0] shift;
    logic [4:0] count;
    logic sclk_prev;
    logic rd_active;
    logic [7:0] rd_shift;
    logic sdout;
    logic sdout_oe;
    logic timing_ref;
    logic sync_req;
    logic [9:0] vod_mv;
  } ccr_state_s;

endpackage

// >>> verilog/ccr_regs.sv
// configuration register slice behind the serial configuration port
`timescale 1ns/1ps

// Operation
// - three-bit master field picks lane amplitude, codes 0..3 map 860 down to 745 mV, codes 4..7 map 960 down to 880 mV
// - bit 3 of 057h picks timing reference source: pins or register bit
// - with register source, bit 4 of 057h sets the timing reference level
// - bit 5 of 058h inverts the sync request input; 0 passes it through
// - four-bit per-channel gain in 0A6h, 1 dB steps, codes 0 to 11
// - digital page 610000h selects channel A, 610100h channel B, with m = 1
// - converter page is page value FFh with m = 0
module ccr_regs
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // serial configuration port
  input wire logic SEN_N,
  input wire logic SCLK,
  input wire logic SDIO,
  output logic SDOUT,
  output logic SDOUT_OE,
  // timing reference and sync request
  input wire logic SYSREF_PIN,
  input wire logic SYNC_REQ_N_PIN,
  output logic TIMING_REF,
  output logic SYNC_REQ,
  // configuration to the data path
  output logic [2:0] LANE_AMPLITUDE,
  output logic [9:0] LANE_VOD_MV,
  output logic LOW_RATE_A,
  output logic LOW_RATE_B,
  output logic [3:0] GAIN_A,
  output logic [3:0] GAIN_B
);
  import ccr_pkg::*;

  ccr_state_s st_q;
  ccr_state_s st_d;
  logic rise;
  logic fall;
  logic [15:0] hdr;
  logic [23:0] word;
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_m;
  logic hit_master;
  logic hit_conv;
  logic hit_dig_a;
  logic hit_dig_b;

  // amplitude code to millivolts
  function automatic logic [9:0] vod_of(input logic [2:0] code);
    case (code)
      3'h0: vod_of = CCR_VOD_MV_0;
      3'h1: vod_of = CCR_VOD_MV_1;
      3'h2: vod_of = CCR_VOD_MV_2;
      3'h3: vod_of = CCR_VOD_MV_3;
      3'h4: vod_of = CCR_VOD_MV_4;
      3'h5: vod_of = CCR_VOD_MV_5;
      3'h6: vod_of = CCR_VOD_MV_6;
      default: vod_of = CCR_VOD_MV_7;
    endcase
  endfunction

  // readback of one register, reserved bits as zero, unmapped as zero
  function automatic logic [7:0] read_of(input ccr_state_s s, input logic m,
                                         input logic [11:0] a);
    logic [7:0] r;
    logic mas;
    logic cnv;
    logic dga;
    logic dgb;
    r = 8'h00;
    mas = !m && s.analog_page == CCR_PAGE_MASTER;
    cnv = !m && s.analog_page == CCR_PAGE_CONVERTER;
    dga = m && s.dig_page == CCR_PAGE_DIG_CHAN_A;
    dgb = m && s.dig_page == CCR_PAGE_DIG_CHAN_B;
    if (!m && a == CCR_OFS_ANALOG_PAGE)
      r = s.analog_page;
    else if (!m && a == CCR_OFS_DIG_PAGE_LO)
      r = s.dig_page[7:0];
    else if (!m && a == CCR_OFS_DIG_PAGE_MID)
      r = s.dig_page[15:8];
    else if (!m && a == CCR_OFS_DIG_PAGE_HI)
      r = s.dig_page[23:16];
    else if (mas && a == CCR_OFS_LANE_AMPLITUDE_SELECT)
      r[CCR_AMP_LSB +: 3] = s.cfg.lane_amplitude_sel;
    else if (mas && a == CCR_OFS_TIMING_REFERENCE_CONTROL)
    begin
      r[CCR_REF_SRC_BIT] = s.cfg.timing_ref_source_sel;
      r[CCR_REF_LVL_BIT] = s.cfg.timing_ref_level_bit;
    end
    else if (mas && a == CCR_OFS_SYNC_POLARITY_CONTROL)
      r[CCR_SYNC_INV_BIT] = s.cfg.sync_request_invert;
    else if (cnv && a == CCR_OFS_LOW_RATE_ENABLE_ONE)
      r[CCR_LOW_RATE_A_BIT] = s.cfg.low_rate_enable_a;
    else if (cnv && a == CCR_OFS_LOW_RATE_ENABLE_TWO)
      r[CCR_LOW_RATE_B_BIT] = s.cfg.low_rate_enable_b;
    else if (dga && a == CCR_OFS_DIGITAL_GAIN_CONTROL)
      r[CCR_GAIN_LSB +: 4] = s.cfg.gain_a;
    else if (dgb && a == CCR_OFS_DIGITAL_GAIN_CONTROL)
      r[CCR_GAIN_LSB +: 4] = s.cfg.gain_b;
    read_of = r;
  endfunction

  // serial edges and frame decode
  assign rise = !SEN_N && SCLK && !st_q.sclk_prev;
  assign fall = !SEN_N && !SCLK && st_q.sclk_prev;
  assign hdr = {st_q.shift[14:0], SDIO};
  assign word = {st_q.shift, SDIO};
  assign wr_fire = rise && st_q.count == CCR_FRAME_BITS - 5'h01 && !word[23];
  assign wr_m = word[22];
  assign wr_addr = word[19:8];
  assign wr_data = word[7:0];
  assign hit_master = !wr_m && st_q.analog_page == CCR_PAGE_MASTER;
  assign hit_conv = !wr_m && st_q.analog_page == CCR_PAGE_CONVERTER;
  assign hit_dig_a = wr_m && st_q.dig_page == CCR_PAGE_DIG_CHAN_A;
  assign hit_dig_b = wr_m && st_q.dig_page == CCR_PAGE_DIG_CHAN_B;

  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.sclk_prev = SCLK;
    if (SEN_N)
    begin
      st_d.count = 5'h00;
      st_d.rd_active = 1'b0;
      st_d.sdout_oe = 1'b0;
    end
    else if (rise)
    begin
      st_d.shift = word[22:0];
      if (st_q.count != CCR_FRAME_BITS)
        st_d.count = st_q.count + 5'h01;
      if (st_q.count == CCR_HEADER_BITS - 5'h01 && hdr[15])
      begin
        st_d.rd_active = 1'b1;
        st_d.rd_shift = read_of(st_q, hdr[14], hdr[11:0]);
      end
    end
    else if (fall && st_q.rd_active)
    begin
      st_d.sdout = st_q.rd_shift[7];
      st_d.sdout_oe = 1'b1;
      st_d.rd_shift = {st_q.rd_shift[6:0], 1'b0};
      if (st_q.count == CCR_FRAME_BITS)
        st_d.rd_active = 1'b0;
    end
    // register writes, reserved bits dropped
    if (wr_fire)
    begin
      if (!wr_m && wr_addr == CCR_OFS_ANALOG_PAGE)
        st_d.analog_page = wr_data;
      if (!wr_m && wr_addr == CCR_OFS_DIG_PAGE_LO)
        st_d.dig_page[7:0] = wr_data;
      if (!wr_m && wr_addr == CCR_OFS_DIG_PAGE_MID)
        st_d.dig_page[15:8] = wr_data;
      if (!wr_m && wr_addr == CCR_OFS_DIG_PAGE_HI)
        st_d.dig_page[23:16] = wr_data;
      if (hit_master && wr_addr == CCR_OFS_LANE_AMPLITUDE_SELECT)
        st_d.cfg.lane_amplitude_sel = wr_data[CCR_AMP_LSB +: 3];
      if (hit_master && wr_addr == CCR_OFS_TIMING_REFERENCE_CONTROL)
      begin
        st_d.cfg.timing_ref_source_sel = wr_data[CCR_REF_SRC_BIT];
        st_d.cfg.timing_ref_level_bit = wr_data[CCR_REF_LVL_BIT];
      end
      if (hit_master && wr_addr == CCR_OFS_SYNC_POLARITY_CONTROL)
        st_d.cfg.sync_request_invert = wr_data[CCR_SYNC_INV_BIT];
      if (hit_conv && wr_addr == CCR_OFS_LOW_RATE_ENABLE_ONE)
        st_d.cfg.low_rate_enable_a = wr_data[CCR_LOW_RATE_A_BIT];
      if (hit_conv && wr_addr == CCR_OFS_LOW_RATE_ENABLE_TWO)
        st_d.cfg.low_rate_enable_b = wr_data[CCR_LOW_RATE_B_BIT];
      if (hit_dig_a && wr_addr == CCR_OFS_DIGITAL_GAIN_CONTROL)
        st_d.cfg.gain_a = wr_data[CCR_GAIN_LSB +: 4];
      if (hit_dig_b && wr_addr == CCR_OFS_DIGITAL_GAIN_CONTROL)
        st_d.cfg.gain_b = wr_data[CCR_GAIN_LSB +: 4];
    end
    // derived outputs, one cycle behind their causes
    st_d.timing_ref = st_q.cfg.timing_ref_source_sel ?
                      st_q.cfg.timing_ref_level_bit : SYSREF_PIN;
    st_d.sync_req = SYNC_REQ_N_PIN ^ st_q.cfg.sync_request_invert;
    st_d.vod_mv = vod_of(st_q.cfg.lane_amplitude_sel);
  end

  // state register, all fields zero at reset except vod_mv, which loads 860 mV
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q <= '0;
      st_q.cfg.lane_amplitude_sel <= CCR_RST_AMP;
      st_q.cfg.gain_a <= CCR_RST_GAIN;
      st_q.cfg.gain_b <= CCR_RST_GAIN;
      st_q.cfg.timing_ref_source_sel <= CCR_RST_BIT;
      st_q.analog_page <= CCR_RST_ANALOG_PAGE;
      st_q.dig_page <= CCR_RST_DIG_PAGE;
      st_q.vod_mv <= CCR_VOD_MV_0;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from flip-flops
  assign SDOUT = st_q.sdout;
  assign SDOUT_OE = st_q.sdout_oe;
  assign TIMING_REF = st_q.timing_ref;
  assign SYNC_REQ = st_q.sync_req;
  assign LANE_AMPLITUDE = st_q.cfg.lane_amplitude_sel;
  assign LANE_VOD_MV = st_q.vod_mv;
  assign LOW_RATE_A = st_q.cfg.low_rate_enable_a;
  assign LOW_RATE_B = st_q.cfg.low_rate_enable_b;
  assign GAIN_A = st_q.cfg.gain_a;
  assign GAIN_B = st_q.cfg.gain_b;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_gain_write_a;
    wr_fire && hit_dig_a && wr_addr == CCR_OFS_DIGITAL_GAIN_CONTROL;
  endsequence
  sequence s_low_rate_write_a;
    wr_fire && hit_conv && wr_addr == CCR_OFS_LOW_RATE_ENABLE_ONE;
  endsequence

  a_vod_code_four: assert property (
    LANE_AMPLITUDE == 3'h4 ##1 LANE_AMPLITUDE == 3'h4 |-> LANE_VOD_MV == 10'd960)
    else $error("lane amplitude code 4 not 960 mV");
  a_vod_code_three: assert property (
    LANE_AMPLITUDE == 3'h3 ##1 LANE_AMPLITUDE == 3'h3 |-> LANE_VOD_MV == 10'd745)
    else $error("lane amplitude code 3 not 745 mV");
  a_ref_from_pin: assert property (
    !st_q.cfg.timing_ref_source_sel |=> TIMING_REF == $past(SYSREF_PIN))
    else $error("timing reference does not follow pin");
  a_ref_from_reg: assert property (
    st_q.cfg.timing_ref_source_sel |=> TIMING_REF == $past(st_q.cfg.timing_ref_level_bit))
    else $error("timing reference does not follow level bit");
  a_sync_invert: assert property (
    1'b1 |=> SYNC_REQ == ($past(SYNC_REQ_N_PIN) ^ $past(st_q.cfg.sync_request_invert)))
    else $error("sync request polarity wrong");
  a_gain_chan_a: assert property (
    s_gain_write_a |=> GAIN_A == $past(wr_data[3:0]) && $stable(GAIN_B))
    else $error("channel A gain write misrouted");
  a_low_rate_page: assert property (
    s_low_rate_write_a |=> LOW_RATE_A == $past(wr_data[CCR_LOW_RATE_A_BIT]))
    else $error("converter page write not taken");
  a_fields_hold: assert property (
    !wr_fire |=> $stable(st_q.cfg))
    else $error("register field changed without a write");
  a_dig_page_miss: assert property (
    wr_fire && wr_m && !hit_dig_a && !hit_dig_b |=> $stable(GAIN_A) && $stable(GAIN_B))
    else $error("gain written with no channel page selected");
endmodule

// >>> testbench/ccr_host.sv
// host model that sends frames on the serial configuration port
`timescale 1ns/1ps
module ccr_host
(
  // clock
  input wire logic mclk,
  // serial port
  output logic sen_n,
  output logic sclk,
  output logic sdio,
  input wire logic sdout,
  // read result
  output logic rd_valid,
  output logic [7:0] rd_data
);
  // idle port, clock low so the first rise is clean
  initial
  begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdio = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // one frame msb first, sclk two mclk low then two high
  task automatic xfer(input logic rw, input logic m, input logic [11:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {rw, m, 2'b00, a, d};
    @(posedge mclk);
    sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdio <= f[i];
      repeat (2) @(posedge mclk);
      sclk <= 1'b1;
      @(negedge mclk);
      rd_data <= {rd_data[6:0], sdout}; // read bits only change on falls
      repeat (2) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    sen_n <= 1'b1;
    rd_valid <= rw;
    @(posedge mclk);
    rd_valid <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// >>> testbench/ccr_regs_tb.sv
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
module ccr_regs_tb;
  import ccr_pkg::*;
  typedef struct {string nm; logic [31:0] v;} ccr_note_s;
  localparam logic [9:0] vod_tab [8] = '{10'd860, 10'd810, 10'd770, 10'd745,
    10'd960, 10'd930, 10'd905, 10'd880};
  localparam logic [15:0] stim [6] = '{16'h5708, 16'h5718, 16'h5708, 16'h5820,
    16'h5800, 16'h5700};
  logic mclk, sys_rst, sen_n, sclk, sdio, sdout, sdout_oe, ref_pin, sync_pin;
  logic timing_ref, sync_req, low_a, low_b, rd_valid, snap_valid, oe_seen, sdout_line;
  logic m_src, m_lvl, m_inv, m_la, m_lb;
  logic [2:0] lane_amp, m_amp;
  logic [9:0] vod;
  logic [3:0] gain_a, gain_b, m_ga, m_gb, g;
  logic [7:0] rd_data;
  logic [15:0] t;
  logic [23:0] p;
  logic [31:0] snap_data, got;
  int n_errors, check_count;
  ccr_note_s exp_q[$];
  ccr_note_s note;
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ccr_regs ccr_regs_i (.MCLK(mclk), .SYS_RST(sys_rst), .SEN_N(sen_n), .SCLK(sclk),
    .SDIO(sdio), .SDOUT(sdout), .SDOUT_OE(sdout_oe), .SYSREF_PIN(ref_pin),
    .SYNC_REQ_N_PIN(sync_pin), .TIMING_REF(timing_ref), .SYNC_REQ(sync_req),
    .LANE_AMPLITUDE(lane_amp), .LANE_VOD_MV(vod), .LOW_RATE_A(low_a),
    .LOW_RATE_B(low_b), .GAIN_A(gain_a), .GAIN_B(gain_b));
  ccr_host ccr_host_i (.mclk(mclk), .sen_n(sen_n), .sclk(sclk), .sdio(sdio),
    .sdout(sdout_line), .rd_valid(rd_valid), .rd_data(rd_data));
  // released read line shows the inverse of its last bit, so stray samples fail
  assign sdout_line = sdout_oe ? sdout : ~sdout;
  // output enable as last seen inside a frame
  always @(negedge mclk)
  begin
    if (sen_n == 1'b0)
      oe_seen <= sdout_oe;
  end
  // expected outputs from the bench's own copy of the fields
  function automatic logic [31:0] expd();
    return {6'h00, 1'b0, m_src ? m_lvl : ref_pin, sync_pin ^ m_inv, m_la, m_lb, m_ga, m_gb,
      m_amp, vod_tab[m_amp]};
  endfunction
  // note the expectation and present a settled snapshot of all outputs except SDOUT
  task automatic see(input string nm);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    exp_q.push_back('{nm, expd()});
    snap_data <= {6'h00, sdout_oe, timing_ref, sync_req, low_a, low_b, gain_a, gain_b,
      lane_amp, vod};
    snap_valid <= 1'b1;
    @(posedge mclk);
    snap_valid <= 1'b0;
  endtask
  task automatic rd(input logic m, input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back('{$sformatf("reg %h", a), {23'h0, 1'b1, e}});
    ccr_host_i.xfer(1'b1, m, a, 8'h00);
  endtask
  task automatic wr(input logic m, input logic [11:0] a, input logic [7:0] d);
    ccr_host_i.xfer(1'b0, m, a, d);
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0)
      n_errors++;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // compare each result with the oldest note
  always @(posedge mclk)
  begin
    if (rd_valid === 1'b1 || snap_valid === 1'b1)
    begin
      got = (rd_valid === 1'b1) ? {23'h0, oe_seen, rd_data} : snap_data;
      note = exp_q.pop_front();
      check_count++;
      if (got !== note.v)
      begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", note.nm, note.v, got);
      end
    end
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h48bcb56f));
    sys_rst = 1'b1;
    ref_pin = 1'b0;
    sync_pin = 1'b0;
    snap_valid = 1'b0;
    snap_data = 32'h0;
    n_errors = 0;
    check_count = 0;
    {m_src, m_lvl, m_inv, m_la, m_lb, m_amp, m_ga, m_gb} = '0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    see("reset");
    rd(1'b0, CCR_OFS_LANE_AMPLITUDE_SELECT, 8'h00);
    rd(1'b0, CCR_OFS_TIMING_REFERENCE_CONTROL, 8'h00);
    rd(1'b0, CCR_OFS_SYNC_POLARITY_CONTROL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      m_amp = 3'(i);
      wr(1'b0, CCR_OFS_LANE_AMPLITUDE_SELECT, {5'h00, m_amp});
      see("amplitude");
      rd(1'b0, CCR_OFS_LANE_AMPLITUDE_SELECT, {5'h00, m_amp});
    end
    $display("test amplitude done");
    // source select goes up before the level bit is used
    for (int i = 0; i < 6; i++)
    begin
      t = stim[i];
      wr(1'b0, {4'h0, t[15:8]}, t[7:0]);
      if (t[15:8] == 8'h57)
        {m_lvl, m_src} = t[4:3];
      else
        m_inv = t[5];
      for (int k = 0; k < 3; k++)
      begin
        ref_pin <= 1'($urandom);
        sync_pin <= 1'($urandom);
        see("timing and sync");
      end
      rd(1'b0, {4'h0, t[15:8]}, t[7:0]);
    end
    $display("test timing and sync done");
    wr(1'b0, CCR_OFS_LOW_RATE_ENABLE_ONE, 8'h04);
    see("wrong page");
    wr(1'b0, CCR_OFS_ANALOG_PAGE, CCR_PAGE_CONVERTER);
    rd(1'b0, CCR_OFS_ANALOG_PAGE, CCR_PAGE_CONVERTER);
    rd(1'b0, CCR_OFS_LOW_RATE_ENABLE_ONE, 8'h00);
    rd(1'b0, 12'h040, 8'h00);
    {m_la, m_lb} = 2'b11;
    wr(1'b0, CCR_OFS_LOW_RATE_ENABLE_ONE, 8'h04);
    wr(1'b0, CCR_OFS_LOW_RATE_ENABLE_TWO, 8'h10);
    see("low rate");
    rd(1'b0, CCR_OFS_LOW_RATE_ENABLE_TWO, 8'h10);
    m_la = 1'b0;
    wr(1'b0, CCR_OFS_LOW_RATE_ENABLE_ONE, 8'h00);
    see("low rate clear");
    wr(1'b0, CCR_OFS_ANALOG_PAGE, CCR_PAGE_MASTER);
    $display("test low rate done");
    // gain write with no channel page selected must be dropped
    wr(1'b1, CCR_OFS_DIGITAL_GAIN_CONTROL, 8'h05);
    see("gain no page");
    rd(1'b1, CCR_OFS_DIGITAL_GAIN_CONTROL, 8'h00);
    for (int j = 0; j < 4; j++)
    begin
      g = (j < 2) ? 4'hb : 4'($urandom_range(10, 0));
      p = (j % 2 == 1) ? CCR_PAGE_DIG_CHAN_B : CCR_PAGE_DIG_CHAN_A;
      wr(1'b0, CCR_OFS_DIG_PAGE_LO, p[7:0]);
      wr(1'b0, CCR_OFS_DIG_PAGE_MID, p[15:8]);
      wr(1'b0, CCR_OFS_DIG_PAGE_HI, p[23:16]);
      rd(1'b0, CCR_OFS_DIG_PAGE_MID, p[15:8]);
      if (j % 2 == 1)
        m_gb = g;
      else
        m_ga = g;
      wr(1'b1, CCR_OFS_DIGITAL_GAIN_CONTROL, {4'h0, g});
      see("gain");
      rd(1'b1, CCR_OFS_DIGITAL_GAIN_CONTROL, {4'h0, g});
    end
    $display("test gain done");
    // reset in mid-run brings every field back to zero
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    {m_src, m_lvl, m_inv, m_la, m_lb, m_amp, m_ga, m_gb} = '0;
    see("second reset");
    rd(1'b1, CCR_OFS_DIGITAL_GAIN_CONTROL, 8'h00);
    $display("test second reset done");
    wrap_up();
  end
endmodule
